// File: hw/fsc_cyc_if.sv
// Request and answer signals for one flash bus cycle.
`timescale 1ns/1ps
interface fsc_cyc_if #(parameter int AW = 21);
  logic          req;    // One-cycle request.
  logic          wr;     // High for a write cycle.
  logic [AW-1:0] addr;   // Cycle address.
  logic [15:0]   wdata;  // Write data.
  logic          done;   // One-cycle end of cycle.
  logic [15:0]   rdata;  // Data captured by a read.

  modport ctl (output req, output wr, output addr, output wdata,
               input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata,
               output done, output rdata);
endinterface

// File: hw/fsc_cycle.sv
// Pin engine that runs one asynchronous flash read or write cycle.
`timescale 1ns/1ps
`include "fsc_defines.svh"
module fsc_cycle #(
  parameter int AW = 21
) (
  input  wire logic          aclk,        // System clock.
  input  wire logic          aresetn,     // Synchronous reset, low.
  fsc_cyc_if.eng             cyc,         // Cycle request and answer.
  output logic [AW-1:0]      flash_addr,  // Address pins.
  output logic               flash_ce_n,  // Chip select, low.
  output logic               flash_oe_n,  // Output enable, low.
  output logic               flash_we_n,  // Write strobe, low.
  input  wire logic [15:0]   flash_dq_i,  // Data pins in.
  output logic [15:0]        flash_dq_o,  // Data pins out.
  output logic               flash_dq_oe_n // Low while driving data.
);
  fsc_pkg::fsc_cyc_state_t st_q;
  logic [7:0]  cnt_q;
  logic        wr_q;
  logic        done_q;
  logic [15:0] rdata_q;
  logic [15:0] s1_q, s2_q, s3_q;
  logic        dq_stable;

  assign cyc.done  = done_q;
  assign cyc.rdata = rdata_q;
  // Data from the pins is only trusted once two later stages agree.
  assign dq_stable = (s2_q == s3_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 16'h0000;
      s2_q <= 16'h0000;
      s3_q <= 16'h0000;
    end else begin
      s1_q <= flash_dq_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q          <= fsc_pkg::CY_IDLE;
      cnt_q         <= 8'h00;
      wr_q          <= 1'b0;
      done_q        <= 1'b0;
      rdata_q       <= 16'h0000;
      flash_addr    <= '0;
      flash_ce_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_dq_o    <= 16'h0000;
      flash_dq_oe_n <= 1'b1;
    end else begin
      case (st_q)
        fsc_pkg::CY_IDLE: begin
          done_q <= 1'b0;
          if (cyc.req) begin
            wr_q          <= cyc.wr;
            flash_addr    <= cyc.addr;
            flash_dq_o    <= cyc.wdata;
            flash_dq_oe_n <= ~cyc.wr;
            flash_ce_n    <= 1'b0;
            flash_we_n    <= ~cyc.wr;
            flash_oe_n    <= cyc.wr;
            cnt_q <= cyc.wr ? 8'(`FSC_WP_CYC)
                            : 8'(`FSC_ACC_CYC + `FSC_SYNC_CYC);
            st_q  <= fsc_pkg::CY_LOW;
          end
        end
        fsc_pkg::CY_LOW: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (wr_q || dq_stable) begin
            rdata_q    <= s3_q;
            flash_ce_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            cnt_q      <= 8'(`FSC_HI_CYC);
            st_q       <= fsc_pkg::CY_HIGH;
          end
        end
        fsc_pkg::CY_HIGH: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            done_q        <= 1'b1;
            flash_dq_oe_n <= 1'b1;
            st_q          <= fsc_pkg::CY_IDLE;
          end
        end
        default: st_q <= fsc_pkg::CY_IDLE;
      endcase
    end
  end
endmodule // fsc_cycle

// File: hw/fsc_defines.svh
// Offsets, command codes, status bit positions and timing counts.
`ifndef FSC_DEFINES_SVH
`define FSC_DEFINES_SVH

`define FSC_CLK_NS          25
`define FSC_CYC_UP(ns)      (((ns) + `FSC_CLK_NS - 1) / `FSC_CLK_NS)

// Least pin timings in ns, rounded up to whole clock cycles below.
`define FSC_T_WP_NS         70
`define FSC_T_ACC_NS        90
`define FSC_T_HI_NS         30
`define FSC_T_PLPH_NS       100
`define FSC_T_PHWL_NS       150
`define FSC_WP_CYC          `FSC_CYC_UP(`FSC_T_WP_NS)
`define FSC_ACC_CYC         `FSC_CYC_UP(`FSC_T_ACC_NS)
`define FSC_HI_CYC          `FSC_CYC_UP(`FSC_T_HI_NS)
`define FSC_PLPH_CYC        `FSC_CYC_UP(`FSC_T_PLPH_NS)
`define FSC_PHWL_CYC        `FSC_CYC_UP(`FSC_T_PHWL_NS)
`define FSC_SYNC_CYC        3

`define FSC_OFF_CTRL        8'h00
`define FSC_OFF_ADDR        8'h04
`define FSC_OFF_WDATA       8'h08
`define FSC_OFF_RDATA       8'h0C
`define FSC_OFF_STAT        8'h10

`define FSC_CMD_READ_ARRAY  8'hFF
`define FSC_CMD_QUERY       8'h98
`define FSC_CMD_STATUS      8'h70
`define FSC_CMD_CLEAR       8'h50
`define FSC_CMD_PROGRAM     8'h40
`define FSC_CMD_SUSPEND     8'hB0
`define FSC_CMD_RESUME      8'hD0

`define FSC_SR_READY        7
`define FSC_SR_PSUSP        2

`define FSC_RESP_OKAY       2'b00
`define FSC_RESP_SLVERR     2'b10

`endif

// File: hw/fsc_pkg.sv
// Types shared by the flash sequencer modules.
package fsc_pkg;
  typedef enum logic [2:0] {
    OP_ARRAY, OP_QUERY, OP_STATUS, OP_CLEAR,
    OP_PROG, OP_SUSP, OP_RESUME, OP_RESET
  } fsc_op_t;

  typedef enum logic [3:0] {
    ST_RST_LOW, ST_RST_WAIT, ST_IDLE, ST_CMD, ST_DATA,
    ST_RD, ST_POLL, ST_CLR, ST_FIN
  } fsc_state_t;

  typedef enum logic [1:0] {
    CY_IDLE, CY_LOW, CY_HIGH
  } fsc_cyc_state_t;
endpackage

// File: hw/fsc_top.sv
// Flash command sequencer with an AXI4-Lite register port.
`timescale 1ns/1ps
`include "fsc_defines.svh"
// How it works
// - Query op writes query code, then reads structure data at ADDR.
// - Read-array code precedes array reads and ends every program.
// - Select and output enable rise between every two status reads.
// - Program op writes setup code, then address and data.
// - While programming, only suspend is accepted from software.
// - After each program, host clears status and returns to array.
// - While suspended, only array, status, query and resume accepted.
// - Reset op is refused while programming is suspended.
module fsc_top #(
  parameter int AW = 21
) (
  input  wire logic          aclk,             // System clock.
  input  wire logic          aresetn,          // Synchronous reset, low.
  input  wire logic [7:0]    s_axi_awaddr,     // Write address.
  input  wire logic          s_axi_awvalid,    // Write address valid.
  output logic               s_axi_awready,    // Write address ready.
  input  wire logic [31:0]   s_axi_wdata,      // Write data.
  input  wire logic [3:0]    s_axi_wstrb,      // Write strobes.
  input  wire logic          s_axi_wvalid,     // Write data valid.
  output logic               s_axi_wready,     // Write data ready.
  output logic [1:0]         s_axi_bresp,      // Write response.
  output logic               s_axi_bvalid,     // Write response valid.
  input  wire logic          s_axi_bready,     // Write response ready.
  input  wire logic [7:0]    s_axi_araddr,     // Read address.
  input  wire logic          s_axi_arvalid,    // Read address valid.
  output logic               s_axi_arready,    // Read address ready.
  output logic [31:0]        s_axi_rdata,      // Read data.
  output logic [1:0]         s_axi_rresp,      // Read response.
  output logic               s_axi_rvalid,     // Read data valid.
  input  wire logic          s_axi_rready,     // Read data ready.
  output logic [AW-1:0]      flash_addr,       // Flash address pins.
  output logic               flash_ce_n,       // Flash chip select.
  output logic               flash_oe_n,       // Flash output enable.
  output logic               flash_we_n,       // Flash write strobe.
  input  wire logic [15:0]   flash_dq_i,       // Flash data in.
  output logic [15:0]        flash_dq_o,       // Flash data out.
  output logic               flash_dq_oe_n,    // Low while driving data.
  output logic               reset_powerdown_n // Flash reset, low.
);
  ////////////////////////////////////////////////////////////////////////
  fsc_cyc_if #(.AW(AW)) cyc ();

  fsc_cycle #(.AW(AW)) u_cycle (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .cyc           (cyc),
    .flash_addr    (flash_addr),
    .flash_ce_n    (flash_ce_n),
    .flash_oe_n    (flash_oe_n),
    .flash_we_n    (flash_we_n),
    .flash_dq_i    (flash_dq_i),
    .flash_dq_o    (flash_dq_o),
    .flash_dq_oe_n (flash_dq_oe_n)
  );

  function automatic logic [7:0] fsc_cmd(input fsc_pkg::fsc_op_t op);
    case (op)
      fsc_pkg::OP_QUERY:  fsc_cmd = `FSC_CMD_QUERY;
      fsc_pkg::OP_STATUS: fsc_cmd = `FSC_CMD_STATUS;
      fsc_pkg::OP_CLEAR:  fsc_cmd = `FSC_CMD_CLEAR;
      fsc_pkg::OP_PROG:   fsc_cmd = `FSC_CMD_PROGRAM;
      fsc_pkg::OP_SUSP:   fsc_cmd = `FSC_CMD_SUSPEND;
      fsc_pkg::OP_RESUME: fsc_cmd = `FSC_CMD_RESUME;
      default:            fsc_cmd = `FSC_CMD_READ_ARRAY;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  fsc_pkg::fsc_state_t state_q, state_d;
  fsc_pkg::fsc_op_t    op_q, op_d, new_op;
  logic [7:0]    cnt_q, cnt_d, sr_q, sr_d;
  logic [15:0]   rdata_q, rdata_d;
  logic [AW-1:0] addr_q, iss_adr;
  logic [15:0]   wdata_q, iss_dat;
  logic          iss, iss_wr, req_q, wr_q;
  logic [AW-1:0] cadr_q;
  logic [15:0]   cdat_q;
  logic          susp_q, susp_d, pend_q, pend_d, pact_q, pact_d;
  logic          refused_q, bvalid_q, rvalid_q, rp_q;
  logic [1:0]    bresp_q, rresp_q;
  logic [31:0]   rd_q;

  wire wr_fire  = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  wire rd_fire  = s_axi_arvalid & ~rvalid_q;
  wire ctrl_hit = wr_fire & (s_axi_awaddr == `FSC_OFF_CTRL);
  wire addr_hit = wr_fire & (s_axi_awaddr == `FSC_OFF_ADDR);
  wire wdat_hit = wr_fire & (s_axi_awaddr == `FSC_OFF_WDATA);
  wire wmapped  = ctrl_hit | addr_hit | wdat_hit |
                  (s_axi_awaddr == `FSC_OFF_RDATA) |
                  (s_axi_awaddr == `FSC_OFF_STAT);
  wire in_idle  = (state_q == fsc_pkg::ST_IDLE);
  wire sr_ready = cyc.rdata[`FSC_SR_READY];
  wire sr_psusp = cyc.rdata[`FSC_SR_PSUSP];
  assign new_op = fsc_pkg::fsc_op_t'(s_axi_wdata[2:0]);
  wire prog_run = (state_q == fsc_pkg::ST_POLL) &
                  ((op_q == fsc_pkg::OP_PROG) | (op_q == fsc_pkg::OP_RESUME));
  wire ok_susp  = (new_op == fsc_pkg::OP_ARRAY) |
                  (new_op == fsc_pkg::OP_STATUS) |
                  (new_op == fsc_pkg::OP_QUERY) |
                  (new_op == fsc_pkg::OP_RESUME);
  wire ok_run   = (new_op != fsc_pkg::OP_SUSP) &
                  (new_op != fsc_pkg::OP_RESUME);
  wire start    = ctrl_hit & in_idle & (susp_q ? ok_susp : ok_run);
  wire susp_req = ctrl_hit & prog_run & (new_op == fsc_pkg::OP_SUSP) &
                  ~pend_q;
  wire refuse   = ctrl_hit & ~start & ~susp_req;

  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = rd_fire;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rd_q;
  assign cyc.req       = req_q;
  assign cyc.wr        = wr_q;
  assign cyc.addr      = cadr_q;
  assign cyc.wdata     = cdat_q;
  assign reset_powerdown_n = rp_q;

  wire [31:0] stat_word = {20'h0_0000, pact_q, refused_q, susp_q,
                           ~in_idle, sr_q};
  wire [31:0] rd_word =
    (s_axi_araddr == `FSC_OFF_CTRL)  ? {29'h0000_0000, op_q} :
    (s_axi_araddr == `FSC_OFF_ADDR)  ? 32'(addr_q) :
    (s_axi_araddr == `FSC_OFF_WDATA) ? {16'h0000, wdata_q} :
    (s_axi_araddr == `FSC_OFF_RDATA) ? {16'h0000, rdata_q} :
    (s_axi_araddr == `FSC_OFF_STAT)  ? stat_word : 32'h0000_0000;
  wire rmapped = (s_axi_araddr == `FSC_OFF_CTRL) |
                 (s_axi_araddr == `FSC_OFF_ADDR) |
                 (s_axi_araddr == `FSC_OFF_WDATA) |
                 (s_axi_araddr == `FSC_OFF_RDATA) |
                 (s_axi_araddr == `FSC_OFF_STAT);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    op_d    = op_q;
    cnt_d   = (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;
    sr_d    = sr_q;
    rdata_d = rdata_q;
    susp_d  = susp_q;
    pend_d  = pend_q | susp_req;
    pact_d  = pact_q;
    iss     = 1'b0;
    iss_wr  = 1'b1;
    iss_adr = addr_q;
    iss_dat = wdata_q;
    case (state_q)
      fsc_pkg::ST_RST_LOW: begin
        if (cnt_q == 8'h00) begin
          cnt_d   = 8'(`FSC_PHWL_CYC);
          state_d = fsc_pkg::ST_RST_WAIT;
        end
      end
      fsc_pkg::ST_RST_WAIT: begin
        if (cnt_q == 8'h00) begin
          sr_d    = 8'h80;
          state_d = fsc_pkg::ST_IDLE;
        end
      end
      fsc_pkg::ST_IDLE: begin
        if (start) begin
          op_d = new_op;
          if (new_op == fsc_pkg::OP_RESUME) begin
            susp_d = 1'b0;
          end
          if (new_op == fsc_pkg::OP_PROG) begin
            pact_d = 1'b1;
          end
          if (new_op == fsc_pkg::OP_RESET) begin
            cnt_d   = 8'(`FSC_PLPH_CYC);
            pact_d  = 1'b0;
            state_d = fsc_pkg::ST_RST_LOW;
          end else begin
            iss     = 1'b1;
            iss_dat = {8'h00, fsc_cmd(new_op)};
            state_d = fsc_pkg::ST_CMD;
          end
        end
      end
      fsc_pkg::ST_CMD: begin
        if (cyc.done) begin
          case (op_q)
            fsc_pkg::OP_CLEAR: state_d = fsc_pkg::ST_IDLE;
            fsc_pkg::OP_PROG: begin
              iss     = 1'b1;
              state_d = fsc_pkg::ST_DATA;
            end
            fsc_pkg::OP_SUSP, fsc_pkg::OP_RESUME: begin
              iss     = 1'b1;
              iss_wr  = 1'b0;
              state_d = fsc_pkg::ST_POLL;
            end
            default: begin
              iss     = 1'b1;
              iss_wr  = 1'b0;
              state_d = fsc_pkg::ST_RD;
            end
          endcase
        end
      end
      fsc_pkg::ST_DATA: begin
        if (cyc.done) begin
          iss     = 1'b1;
          iss_wr  = 1'b0;
          state_d = fsc_pkg::ST_POLL;
        end
      end
      fsc_pkg::ST_RD: begin
        if (cyc.done) begin
          rdata_d = cyc.rdata;
          if (op_q == fsc_pkg::OP_STATUS) begin
            sr_d = cyc.rdata[7:0];
          end
          state_d = fsc_pkg::ST_IDLE;
        end
      end
      fsc_pkg::ST_POLL: begin
        if (cyc.done) begin
          sr_d    = cyc.rdata[7:0];
          rdata_d = cyc.rdata;
          iss     = 1'b1;
          if (op_q == fsc_pkg::OP_SUSP && sr_ready && sr_psusp) begin
            iss     = 1'b0;
            susp_d  = 1'b1;
            state_d = fsc_pkg::ST_IDLE;
          end else if (sr_ready) begin
            iss_dat = {8'h00, `FSC_CMD_CLEAR};
            state_d = fsc_pkg::ST_CLR;
          end else if (pend_q && op_q != fsc_pkg::OP_SUSP) begin
            pend_d  = 1'b0;
            op_d    = fsc_pkg::OP_SUSP;
            iss_dat = {8'h00, `FSC_CMD_SUSPEND};
            state_d = fsc_pkg::ST_CMD;
          end else begin
            iss_wr = 1'b0;
          end
        end
      end
      fsc_pkg::ST_CLR: begin
        if (cyc.done) begin
          iss     = 1'b1;
          iss_dat = {8'h00, `FSC_CMD_READ_ARRAY};
          state_d = fsc_pkg::ST_FIN;
        end
      end
      fsc_pkg::ST_FIN: begin
        if (cyc.done) begin
          pact_d  = 1'b0;
          pend_d  = 1'b0;
          state_d = fsc_pkg::ST_IDLE;
        end
      end
      default: state_d = fsc_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= fsc_pkg::ST_RST_LOW;
      op_q    <= fsc_pkg::OP_ARRAY;
      cnt_q   <= 8'(`FSC_PLPH_CYC);
      sr_q    <= 8'h00;
      rdata_q <= 16'h0000;
      susp_q  <= 1'b0;
      pend_q  <= 1'b0;
      pact_q  <= 1'b0;
      rp_q    <= 1'b0;
      req_q   <= 1'b0;
      wr_q    <= 1'b0;
      cadr_q  <= '0;
      cdat_q  <= 16'h0000;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      cnt_q   <= cnt_d;
      sr_q    <= sr_d;
      rdata_q <= rdata_d;
      susp_q  <= susp_d;
      pend_q  <= pend_d;
      pact_q  <= pact_d;
      rp_q    <= (state_d != fsc_pkg::ST_RST_LOW);
      req_q   <= iss;
      wr_q    <= iss_wr;
      cadr_q  <= iss_wr ? addr_q : iss_adr;
      cdat_q  <= iss_dat;
    end
  end

  // Write data uses only the low two byte lanes; an address write with any strobe set loads all AW bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q    <= '0;
      wdata_q   <= 16'h0000;
      refused_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `FSC_RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= `FSC_RESP_OKAY;
      rd_q      <= 32'h0000_0000;
    end else begin
      if (addr_hit && (s_axi_wstrb != 4'h0)) begin
        addr_q <= s_axi_wdata[AW-1:0];
      end
      if (wdat_hit && (s_axi_wstrb[1:0] != 2'b00)) begin
        wdata_q <= s_axi_wdata[15:0];
      end
      refused_q <= refuse | (refused_q & ~start);
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wmapped ? `FSC_RESP_OKAY : `FSC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rd_q     <= rd_word;
        rresp_q  <= rmapped ? `FSC_RESP_OKAY : `FSC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
endmodule // fsc_top

// File: testbench/fsc_flash_model.sv
// Behavioural flash device that answers the sequencer's pins.
`timescale 1ns/1ps
module fsc_flash_model (
  input  wire logic [20:0] a,     // Address pins.
  input  wire logic        ce_n,  // Chip select, low.
  input  wire logic        oe_n,  // Output enable, low.
  input  wire logic        we_n,  // Write strobe, low.
  input  wire logic [15:0] d_in,  // Data level on the pins.
  input  wire logic        rp_n,  // Reset/power-down, low.
  input  wire logic [2:0]  flt,   // Lock, supply, verify faults.
  output logic      [15:0] d_out  // Data to the host.
);
  logic [15:0] mem [16];
  logic [15:0] pd, sq, drv;
  logic [15:0] last = 16'h0000;
  logic [7:0]  sr, c;
  logic [3:0]  pa;
  logic [1:0]  md;
  logic        pset, susp, sreq;
  int          cnt;
  assign c = d_in[7:0];
  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  always @(rp_n) if (!rp_n) begin
    sr = 8'h80;
    md = 2'd0;
    pset = 1'b0;
    susp = 1'b0;
    sreq = 1'b0;
    cnt = 0;
  end
  always @(posedge we_n) if (rp_n) begin
    if (pset) begin
      pset = 1'b0;
      md = 2'd2;
      if (flt[1]) sr[3] = 1'b1;
      else if (flt[0]) sr[1] = 1'b1;
      else begin
        pa = a[3:0];
        pd = d_in;
        sr[7] = 1'b0;
        cnt = 80;
      end
    end else if (cnt > 0 && !susp) begin
      sreq = sreq | (c == 8'hB0);
    end else case (c)
      8'hFF: md = 2'd0;
      8'h98: md = 2'd1;
      8'h70: md = 2'd2;
      8'h50: if (!susp) sr = sr & 8'hC5;
      8'h40: if (!susp) pset = 1'b1;
      8'hD0: if (susp) begin
        susp = 1'b0;
        sr = sr & 8'h7B;
        md = 2'd2;
      end
      default: ;
    endcase
  end
  always #25 if (cnt > 0 && sreq) begin
    sreq = 1'b0;
    susp = 1'b1;
    sr = sr | 8'h84;
  end else if (cnt > 0 && !susp) begin
    cnt = cnt - 1;
    if (cnt == 0) begin
      mem[pa] = mem[pa] & pd;
      sr = sr | {3'b100, flt[2], 4'h0};
    end
  end
  always @(negedge ce_n or negedge oe_n)
    if (!ce_n && !oe_n) sq = {8'h00, sr};
  assign drv = md == 2'd2 ? sq : md == 2'd1 ? {8'h51, a[7:0]} : mem[a[3:0]];
  // Released pins show the inverse so stale data never passes as valid.
  always @(posedge oe_n) last = drv;
  assign d_out = (ce_n || oe_n) ? ~last : drv;
endmodule // fsc_flash_model

// File: testbench/fsc_top_chk.sv
// Concurrent checks on the flash pins of the sequencer.
`timescale 1ns/1ps
module fsc_top_chk (
  input wire logic aclk,              // System clock.
  input wire logic aresetn,           // Reset, low.
  input wire logic flash_ce_n,        // Chip select.
  input wire logic flash_oe_n,        // Output enable.
  input wire logic flash_we_n,        // Write strobe.
  input wire logic flash_dq_oe_n,     // Data drive, low.
  input wire logic reset_powerdown_n  // Flash reset.
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  strobe_width_a: assert property ($fell(flash_we_n) |->
    !flash_we_n [*4] ##1 flash_we_n) else $error("strobe width");
  strobe_edges_a: assert property ($rose(flash_we_n) |->
    $rose(flash_ce_n)) else $error("strobe and select apart");
  data_hold_a: assert property ($rose(flash_we_n) |->
    !flash_dq_oe_n [*2]) else $error("write data hold");
  no_clash_a: assert property (!flash_oe_n |->
    flash_dq_oe_n && flash_we_n) else $error("data clash");
  read_width_a: assert property ($fell(flash_oe_n) |->
    !flash_oe_n [*7]) else $error("read too short");
  poll_gap_a: assert property ($rose(flash_oe_n) |->
    (flash_oe_n && flash_ce_n) [*2]) else $error("no toggle gap");
  rp_pulse_a: assert property ($fell(reset_powerdown_n) |->
    !reset_powerdown_n [*5] ##1 reset_powerdown_n) else $error("rp pulse");
  wake_gap_a: assert property ($rose(reset_powerdown_n) |->
    flash_ce_n [*6]) else $error("access too soon");
  quiet_rst_a: assert property (!reset_powerdown_n |->
    flash_ce_n && flash_dq_oe_n) else $error("access in reset");
  cover property ($rose(flash_we_n));
  cover property ($fell(flash_oe_n));
  cover property ($fell(reset_powerdown_n));
endmodule // fsc_top_chk
bind fsc_top fsc_top_chk u_chk (.aclk, .aresetn, .flash_ce_n,
  .flash_oe_n, .flash_we_n, .flash_dq_oe_n, .reset_powerdown_n);

// File: testbench/fsc_top_tb_top.sv
// Register-level tests of the flash sequencer against a flash model.
`timescale 1ns/1ps
module fsc_top_tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, s;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [20:0] flash_addr;
  logic        flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n;
  logic        reset_powerdown_n;
  logic [15:0] flash_dq_i, flash_dq_o, mdq;
  logic [2:0]  flt = 3'b000;
  logic [31:0] ek [3] = '{32'h0000_0082, 32'h0000_0088, 32'h0000_0090};
  int          bad_count = 0, num_checks = 0;

  always #12.5 aclk = ~aclk;
  assign flash_dq_i = flash_dq_oe_n ? mdq : flash_dq_o;

  fsc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_addr,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_i, .flash_dq_o,
    .flash_dq_oe_n, .reset_powerdown_n);
  fsc_flash_model u_flash (.a(flash_addr), .ce_n(flash_ce_n),
    .oe_n(flash_oe_n), .we_n(flash_we_n), .d_in(flash_dq_i),
    .rp_n(reset_powerdown_n), .flt, .d_out(mdq));

  ////////////////////////////////////////
  task automatic tally_and_finish;
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic lim(input int n);
    if (n >= 500) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  task automatic ck(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axw(input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_awready && n < 500);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (!s_axi_bvalid && n < 500) begin
      @(posedge aclk);
      n++;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    lim(n);
  endtask
  task automatic axr(input logic [7:0] ad, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_arready && n < 500);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid && n < 500) begin
      @(posedge aclk);
      n++;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    lim(n);
  endtask
  task automatic op(input logic [2:0] c);
    axw(8'h00, {29'h0000_0000, c});
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      axr(8'h10, s);
      n++;
    end while (s[8] !== 1'b0 && n < 500);
    lim(n);
  endtask
  // A flash read lands in the read-data register once the op is idle.
  task automatic fr(input logic [2:0] c, input logic [31:0] ad);
    axw(8'h04, ad);
    op(c);
    idle;
    axr(8'h0C, s);
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    idle;
    ck("stat", 32'h0000_0080, s);
    fr(3'd1, 32'h0000_0005);
    ck("query", 32'h0000_5105, s);
    axw(8'h04, 32'h0000_0003);
    axw(8'h08, 32'h0000_1234);
    op(3'd4);
    idle;
    ck("stat", 32'h0000_0080, s);
    fr(3'd0, 32'h0000_0003);
    ck("array", 32'h0000_1234, s);
    axw(8'h08, 32'h0000_FF0F);
    op(3'd4);
    idle;
    fr(3'd0, 32'h0000_0003);
    ck("array", 32'h0000_1204, s);
    fr(3'd2, 32'h0000_0000);
    ck("status", 32'h0000_0080, s);
    for (int i = 0; i < 3; i++) begin
      flt <= 3'b001 << i;
      axw(8'h04, 32'h0000_0003);
      op(3'd4);
      idle;
      ck("fault", ek[i], s);
    end
    flt <= 3'b000;
    fr(3'd2, 32'h0000_0000);
    ck("status", 32'h0000_0080, s);
    op(3'd5);
    axr(8'h10, s);
    ck("refused", 32'h0000_0480, s);
    op(3'd6);
    axr(8'h10, s);
    ck("refused", 32'h0000_0480, s);
    axw(8'h08, 32'h0000_00F0);
    op(3'd4);
    repeat (20) @(posedge aclk);
    op(3'd2);
    axr(8'h10, s);
    ck("busy", 32'h0000_0D00, s & 32'h0000_FF00);
    op(3'd5);
    idle;
    ck("susp", 32'h0000_0E84, s);
    op(3'd4);
    op(3'd7);
    axr(8'h10, s);
    ck("susp", 32'h0000_0E84, s);
    fr(3'd1, 32'h0000_0002);
    ck("query", 32'h0000_5102, s);
    op(3'd6);
    idle;
    ck("stat", 32'h0000_0080, s);
    fr(3'd0, 32'h0000_0000);
    ck("array", 32'h0000_00F0, s);
    op(3'd7);
    idle;
    fr(3'd2, 32'h0000_0000);
    ck("status", 32'h0000_0080, s);
    axr(8'h20, s);
    ck("rresp", 32'h0000_0002, {30'h0000_0000, r});
    ck("rdata", 32'h0000_0000, s);
    axw(8'h24, 32'h0000_0001);
    ck("bresp", 32'h0000_0002, {30'h0000_0000, r});
    tally_and_finish();
  end
endmodule // fsc_top_tb_top
